//--- pin_select_cfg.svh
`ifndef PIN_SELECT_CFG_SVH
`define PIN_SELECT_CFG_SVH

// ************************************************************
// Register offsets (byte addresses on the APB bus)
// ************************************************************
`define OSC_CONTROL_OFFSET      12'h000
`define INPUT_MAP_OFFSET        12'h004
`define OUTPUT_MAP_OFFSET       12'h008
`define EVENT_STATUS_OFFSET     12'h00c
`define EVENT_MASK_OFFSET       12'h010

// ************************************************************
// Field positions, keys and reset values
// ************************************************************
`define MAP_WRITE_LOCK_BIT      6
`define UNLOCK_KEY_FIRST        8'h46
`define UNLOCK_KEY_SECOND       8'h57
`define INPUT_MAP_RESET         16'h1f1f
`define INPUT_MAP_MASK          16'h1f1f
`define OUTPUT_MAP_RESET        16'h0000
`define OUTPUT_MAP_MASK         16'h1f1f
`define SPI2_CLK_SEL_LSB        8
`define SPI2_DATA_SEL_LSB       0
`define PIN_COUNT               26
`define EVENT_WIDTH             2
`define EVENT_MISMATCH_BIT      0
`define EVENT_BLOCKED_BIT       1
`define EVENT_MASK_RESET        2'h0
`define SINGLE_SESSION_RESET    1'b1
`define STRAP_SETTLE_CYCLES     2'h3

`endif

//--- pin_select_pkg.sv
package pin_select_pkg;

    // ************************************************************
    // Bus carriers
    // ************************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // ************************************************************
    // Unlock key sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_FIRST = 3'b010,
        KEY_ARMED = 3'b100
    } key_state_t;

endpackage : pin_select_pkg

//--- pin_select_write_lock.sv
// The address map and the APB slave port were decided locally.
`include "pin_select_cfg.svh"

module pin_select_write_lock (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire pin_select_pkg::apb_req_t  apb_req,
    output pin_select_pkg::apb_rsp_t       apb_rsp,
    input  wire logic [25:0]               remappable_pin,
    input  wire logic                      single_session_lock_cfg,
    output logic                           spi2_clk_in,
    output logic                           spi2_data_in,
    output logic [15:0]                    output_map,
    output logic                           mismatch_reset,
    output logic                           irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [25:0]                 pin_meta;
    logic [25:0]                 pin_sync;
    logic                        strap_meta;
    logic                        strap_sync;
    logic [1:0]                  strap_cnt;
    logic                        single_session;
    pin_select_pkg::key_state_t  key_state;
    pin_select_pkg::key_state_t  next_key_state;
    logic                        map_write_lock;
    logic [15:0]                 input_map;
    logic [15:0]                 shadow_input_map;
    logic [15:0]                 output_map_reg;
    logic [15:0]                 shadow_output_map;
    logic [`EVENT_WIDTH-1:0]     event_status;
    logic [`EVENT_WIDTH-1:0]     event_mask;
    logic [`EVENT_WIDTH-1:0]     event_set;
    logic [`EVENT_WIDTH-1:0]     event_clr;
    logic [31:0]                 read_data;
    logic                        access;
    logic                        wr;
    logic                        sel_osc;
    logic                        sel_in;
    logic                        sel_out;
    logic                        sel_status;
    logic                        sel_mask;
    logic                        mapped;
    logic                        osc_low_wr;
    logic                        map_wr;
    logic                        mismatch_now;
    logic [4:0]                  clk_sel;
    logic [4:0]                  data_sel;

    // Byte-lane merge of a 16-bit map register, unimplemented bits forced low
    function automatic logic [15:0] merge_map(input logic [15:0] old_val, input logic [31:0] wdata,
                                              input logic [3:0] strb);
        logic [15:0] merged;
        merged = old_val;
        if (strb[0]) begin
            merged[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            merged[15:8] = wdata[15:8];
        end
        return merged & `INPUT_MAP_MASK;
    endfunction : merge_map

    // Picks a synchronised pin; selections past the last pin read low
    function automatic logic pick_pin(input logic [25:0] pins, input logic [4:0] sel);
        logic result;
        result = 1'b0;
        if (sel < 5'(`PIN_COUNT)) begin
            result = pins[sel];
        end
        return result;
    endfunction : pick_pin

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Pins pass two flip-flops before the routing reads them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 26'h0;
            pin_sync <= 26'h0;
        end else begin
            pin_meta <= remappable_pin;
            pin_sync <= pin_meta;
        end
    end

    // Configuration strap synchroniser, idles at the unprogrammed level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta <= `SINGLE_SESSION_RESET;
            strap_sync <= `SINGLE_SESSION_RESET;
        end else begin
            strap_meta <= single_session_lock_cfg;
            strap_sync <= strap_meta;
        end
    end

    // Strap captured once after reset release; set until then
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt      <= 2'h0;
            single_session <= `SINGLE_SESSION_RESET;
        end else if (strap_cnt != `STRAP_SETTLE_CYCLES) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == `STRAP_SETTLE_CYCLES - 2'h1) begin
                single_session <= strap_sync;
            end
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    // Transfer completes at the access edge with pready high
    always_comb begin
        access     = apb_req.psel & apb_req.penable & apb_rsp.pready;
        wr         = access & apb_req.pwrite;
        sel_osc    = apb_req.paddr == `OSC_CONTROL_OFFSET;
        sel_in     = apb_req.paddr == `INPUT_MAP_OFFSET;
        sel_out    = apb_req.paddr == `OUTPUT_MAP_OFFSET;
        sel_status = apb_req.paddr == `EVENT_STATUS_OFFSET;
        sel_mask   = apb_req.paddr == `EVENT_MASK_OFFSET;
        mapped     = sel_osc | sel_in | sel_out | sel_status | sel_mask;
        osc_low_wr = wr & sel_osc & apb_req.pstrb[0];
        map_wr     = wr & (sel_in | sel_out);
    end

    // Read mux
    always_comb begin
        read_data = 32'h0;
        case (1'b1)
            sel_osc:    read_data[`MAP_WRITE_LOCK_BIT] = map_write_lock;
            sel_in:     read_data[15:0] = input_map;
            sel_out:    read_data[15:0] = output_map_reg;
            sel_status: read_data[`EVENT_WIDTH-1:0] = event_status;
            sel_mask:   read_data[`EVENT_WIDTH-1:0] = event_mask;
            default:    read_data = 32'h0;
        endcase
    end

    // No wait state: answer raised in the cycle after setup
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready  <= apb_req.psel & ~apb_req.penable & ~apb_rsp.pready;
            apb_rsp.pslverr <= apb_req.psel & ~apb_req.penable & ~apb_rsp.pready & ~mapped;
            if (apb_req.psel & ~apb_req.penable & ~apb_rsp.pready & ~apb_req.pwrite) begin
                apb_rsp.prdata <= read_data;
            end
        end
    end

    // ************************************************************
    // Unlock key sequencer and lock bit
    // ************************************************************
    // Next key state on each low-byte write to oscillator control
    always_comb begin
        next_key_state = key_state;
        if (osc_low_wr) begin
            case (key_state)
                pin_select_pkg::KEY_IDLE: begin
                    if (apb_req.pwdata[7:0] == `UNLOCK_KEY_FIRST && !(single_session && map_write_lock)) begin
                        next_key_state = pin_select_pkg::KEY_FIRST;
                    end
                end
                pin_select_pkg::KEY_FIRST: begin
                    if (apb_req.pwdata[7:0] == `UNLOCK_KEY_SECOND) begin
                        next_key_state = pin_select_pkg::KEY_ARMED;
                    end else begin
                        next_key_state = pin_select_pkg::KEY_IDLE;
                    end
                end
                pin_select_pkg::KEY_ARMED: next_key_state = pin_select_pkg::KEY_IDLE;
                default:                   next_key_state = pin_select_pkg::KEY_IDLE;
            endcase
        end
    end

    // Key state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_state <= pin_select_pkg::KEY_IDLE;
        end else begin
            key_state <= next_key_state;
        end
    end

    // Lock changes only on the write that follows the key
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            map_write_lock <= 1'b0;
        end else if (osc_low_wr && key_state == pin_select_pkg::KEY_ARMED) begin
            if (single_session) begin
                map_write_lock <= map_write_lock | apb_req.pwdata[`MAP_WRITE_LOCK_BIT];
            end else begin
                map_write_lock <= apb_req.pwdata[`MAP_WRITE_LOCK_BIT];
            end
        end
    end

    // ************************************************************
    // Mapping registers and shadows
    // ************************************************************
    // Writes dropped while locked and flagged as a blocked event; shadows follow every accepted write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_map         <= `INPUT_MAP_RESET;
            shadow_input_map  <= `INPUT_MAP_RESET;
            output_map_reg    <= `OUTPUT_MAP_RESET;
            shadow_output_map <= `OUTPUT_MAP_RESET;
        end else if (map_wr && !map_write_lock) begin
            if (sel_in) begin
                input_map        <= merge_map(input_map, apb_req.pwdata, apb_req.pstrb);
                shadow_input_map <= merge_map(input_map, apb_req.pwdata, apb_req.pstrb);
            end else begin
                output_map_reg    <= merge_map(output_map_reg, apb_req.pwdata, apb_req.pstrb);
                shadow_output_map <= merge_map(output_map_reg, apb_req.pwdata, apb_req.pstrb);
            end
        end
    end

    // Continuous comparison against the shadows
    always_comb begin
        mismatch_now = (input_map != shadow_input_map) | (output_map_reg != shadow_output_map);
    end

    // Mismatch reset request and the output map image
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mismatch_reset <= 1'b0;
            output_map     <= `OUTPUT_MAP_RESET;
        end else begin
            mismatch_reset <= mismatch_now;
            output_map     <= output_map_reg;
        end
    end

    // ************************************************************
    // Input routing
    // ************************************************************
    // Selected pin drives each peripheral input
    always_comb begin
        clk_sel  = input_map[`SPI2_CLK_SEL_LSB +: 5];
        data_sel = input_map[`SPI2_DATA_SEL_LSB +: 5];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            spi2_clk_in  <= 1'b0;
            spi2_data_in <= 1'b0;
        end else begin
            spi2_clk_in  <= pick_pin(pin_sync, clk_sel);
            spi2_data_in <= pick_pin(pin_sync, data_sel);
        end
    end

    // ************************************************************
    // Event status, mask and interrupt
    // ************************************************************
    // Sticky events; a new event wins over a same-cycle clear
    always_comb begin
        event_set = '0;
        event_set[`EVENT_MISMATCH_BIT] = mismatch_now;
        event_set[`EVENT_BLOCKED_BIT]  = map_wr & map_write_lock;
        event_clr = (wr && sel_status && apb_req.pstrb[0]) ? apb_req.pwdata[`EVENT_WIDTH-1:0] : '0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_status <= '0;
            event_mask   <= `EVENT_MASK_RESET;
            irq          <= 1'b0;
        end else begin
            event_status <= (event_status & ~event_clr) | event_set;
            if (wr && sel_mask && apb_req.pstrb[0]) begin
                event_mask <= apb_req.pwdata[`EVENT_WIDTH-1:0];
            end
            irq <= |(event_status & event_mask);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_locked_write_keeps;
        (map_wr && map_write_lock) |=> ($stable(input_map) && $stable(output_map_reg));
    endproperty
    a_locked_write_keeps: assert property (p_locked_write_keeps) else $error("locked map write changed a map");

    property p_lock_readback;
        (apb_req.psel && !apb_req.penable && !apb_rsp.pready && !apb_req.pwrite && sel_osc)
            |=> (apb_rsp.prdata[`MAP_WRITE_LOCK_BIT] == $past(map_write_lock) && apb_rsp.pready);
    endproperty
    a_lock_readback: assert property (p_lock_readback) else $error("lock bit read back wrong");

    property p_lock_needs_key;
        $changed(map_write_lock) |-> $past(key_state) == pin_select_pkg::KEY_ARMED;
    endproperty
    a_lock_needs_key: assert property (p_lock_needs_key) else $error("lock changed without key");

    property p_armed_one_shot;
        (osc_low_wr && key_state == pin_select_pkg::KEY_ARMED) |=> key_state == pin_select_pkg::KEY_IDLE;
    endproperty
    a_armed_one_shot: assert property (p_armed_one_shot) else $error("key stayed armed after write");

    property p_unlocked_write_takes;
        (map_wr && sel_in && !map_write_lock && apb_req.pstrb[1:0] == 2'h3)
            |=> input_map == ($past(apb_req.pwdata[15:0]) & `INPUT_MAP_MASK);
    endproperty
    a_unlocked_write_takes: assert property (p_unlocked_write_takes) else $error("unlocked write lost");

    property p_mismatch_flags;
        mismatch_now |=> (mismatch_reset && event_status[`EVENT_MISMATCH_BIT]);
    endproperty
    a_mismatch_flags: assert property (p_mismatch_flags) else $error("mismatch not reported");

    property p_one_way_lock;
        (single_session && map_write_lock) |=> map_write_lock;
    endproperty
    a_one_way_lock: assert property (p_one_way_lock) else $error("single-session lock was cleared");

    property p_key_ignored;
        (single_session && map_write_lock && key_state == pin_select_pkg::KEY_IDLE)
            |=> key_state == pin_select_pkg::KEY_IDLE;
    endproperty
    a_key_ignored: assert property (p_key_ignored) else $error("key accepted while one-way locked");

    property p_route_clk;
        (clk_sel < 5'(`PIN_COUNT)) |=> spi2_clk_in == $past(pin_sync[clk_sel]);
    endproperty
    a_route_clk: assert property (p_route_clk) else $error("clock input routed from wrong pin");

    property p_reserved_zero;
        (input_map[15:13] == 3'h0 && input_map[7:5] == 3'h0
            && output_map_reg[15:13] == 3'h0 && output_map_reg[7:5] == 3'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("unimplemented map bits set");

endmodule : pin_select_write_lock

//--- pin_select_write_lock_tb_top.sv
`include "pin_select_cfg.svh"

module pin_select_write_lock_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Stimulus signals and counters
    // ************************************************************
    logic                     sys_clk = 1'b0;
    logic                     rst_n;
    pin_select_pkg::apb_req_t apb_req;
    pin_select_pkg::apb_rsp_t apb_rsp;
    logic [25:0]              remappable_pin;
    logic                     single_session_lock_cfg;
    logic                     spi2_clk_in;
    logic                     spi2_data_in;
    logic [15:0]              output_map;
    logic                     mismatch_reset;
    logic                     irq;
    int                       mismatches = 0;
    int                       compares = 0;
    logic [31:0]              rdata;
    logic                     rerr;

    // Clock source, 25 ns period
    always #12.5 sys_clk = ~sys_clk;

    pin_select_write_lock dut (
        .sys_clk                 (sys_clk),
        .rst_n                   (rst_n),
        .apb_req                 (apb_req),
        .apb_rsp                 (apb_rsp),
        .remappable_pin          (remappable_pin),
        .single_session_lock_cfg (single_session_lock_cfg),
        .spi2_clk_in             (spi2_clk_in),
        .spi2_data_in            (spi2_data_in),
        .output_map              (output_map),
        .mismatch_reset          (mismatch_reset),
        .irq                     (irq)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // One APB transfer: setup, access held until pready at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        @(posedge sys_clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= w;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= wd;
        apb_req.pstrb   <= s;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (apb_rsp.pready === 1'b1) break;
        end
        if (n == 50) begin
            mismatches++;
            $display("[FAIL] pready expected 1 seen 0");
        end
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] x;
        logic        e;
        xfer(1'b1, a, d, s, x, e);
        check("write error", {31'h0, e}, {31'h0, a > 12'h010});
    endtask : wr

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'h0, rdata, rerr);
        check(n, rdata, exp);
    endtask : rd_chk

    // Key then one lock write, all on the low byte lane
    task automatic lock_seq(input logic [7:0] v);
        wr(`OSC_CONTROL_OFFSET, 32'h46, 4'h1);
        wr(`OSC_CONTROL_OFFSET, 32'h57, 4'h1);
        wr(`OSC_CONTROL_OFFSET, {24'h0, v}, 4'h1);
    endtask : lock_seq

    task automatic do_reset(input logic cfg);
        @(posedge sys_clk);
        rst_n                   <= 1'b0;
        single_session_lock_cfg <= cfg;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask : do_reset

    // ************************************************************
    // Watchdog
    // ************************************************************
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        logic [25:0] p;
        logic [4:0]  k;
        logic [4:0]  kc;
        int          i;
        int          sel [6];
        rst_n                   <= 1'b0;
        apb_req                 <= '0;
        remappable_pin          <= 26'h0;
        single_session_lock_cfg <= 1'b0;
        do_reset(1'b0);

        // Reset values and unmapped access
        rd_chk("osc reset", `OSC_CONTROL_OFFSET, 32'h0);
        rd_chk("input map reset", `INPUT_MAP_OFFSET, 32'h1f1f);
        rd_chk("output map reset", `OUTPUT_MAP_OFFSET, 32'h0);
        rd_chk("status reset", `EVENT_STATUS_OFFSET, 32'h0);
        rd_chk("unmapped read", 12'h014, 32'h0);
        check("unmapped error", {31'h0, rerr}, 32'h1);
        wr(12'h014, 32'hffff_ffff);
        $display("test reset done");

        // Unlocked map writes, reserved bits
        wr(`INPUT_MAP_OFFSET, 32'hffff_ffff);
        rd_chk("input map mask", `INPUT_MAP_OFFSET, 32'h1f1f);
        wr(`INPUT_MAP_OFFSET, 32'h0000_0a05);
        rd_chk("input map write", `INPUT_MAP_OFFSET, 32'h0a05);
        wr(`OUTPUT_MAP_OFFSET, 32'h0000_f2f4);
        rd_chk("output map write", `OUTPUT_MAP_OFFSET, 32'h1214);
        repeat (2) @(posedge sys_clk);
        check("output map port", {16'h0, output_map}, 32'h1214);
        $display("test unlocked done");

        // Input routing for boundary selects, both pin polarities, fields differ
        sel = '{0, 1, 12, 25, 26, 31};
        for (i = 0; i < 6; i++) begin
            k  = sel[i][4:0];
            kc = sel[5 - i][4:0];
            wr(`INPUT_MAP_OFFSET, {19'h0, kc, 3'h0, k});
            p = 26'h2aa_aaaa;
            repeat (2) begin
                @(posedge sys_clk);
                remappable_pin <= p;
                repeat (5) @(posedge sys_clk);
                check("data route", {31'h0, spi2_data_in}, {31'h0, (k < 26) ? p[k] : 1'b0});
                check("clk route", {31'h0, spi2_clk_in}, {31'h0, (kc < 26) ? p[kc] : 1'b0});
                p = ~p;
            end
        end
        $display("test routing done");

        // Lock with unlimited sessions
        wr(`OSC_CONTROL_OFFSET, 32'h40, 4'h1);
        rd_chk("lock without key", `OSC_CONTROL_OFFSET, 32'h0);
        lock_seq(8'h40);
        rd_chk("lock set", `OSC_CONTROL_OFFSET, 32'h40);
        wr(`INPUT_MAP_OFFSET, 32'h0000_0102);
        rd_chk("locked input map", `INPUT_MAP_OFFSET, 32'h001f);
        wr(`OUTPUT_MAP_OFFSET, 32'h0000_0304);
        rd_chk("locked output map", `OUTPUT_MAP_OFFSET, 32'h1214);
        rd_chk("blocked status", `EVENT_STATUS_OFFSET, 32'h2);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(`EVENT_MASK_OFFSET, 32'h2);
        repeat (2) @(posedge sys_clk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(`EVENT_STATUS_OFFSET, 32'h2);
        repeat (2) @(posedge sys_clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd_chk("status cleared", `EVENT_STATUS_OFFSET, 32'h0);
        // Broken key leaves lock alone
        wr(`OSC_CONTROL_OFFSET, 32'h46, 4'h1);
        wr(`OSC_CONTROL_OFFSET, 32'h12, 4'h1);
        wr(`OSC_CONTROL_OFFSET, 32'h57, 4'h1);
        wr(`OSC_CONTROL_OFFSET, 32'h00, 4'h1);
        rd_chk("broken key", `OSC_CONTROL_OFFSET, 32'h40);
        lock_seq(8'h00);
        rd_chk("second session", `OSC_CONTROL_OFFSET, 32'h0);
        wr(`INPUT_MAP_OFFSET, 32'h0000_0102);
        rd_chk("reopened map", `INPUT_MAP_OFFSET, 32'h0102);
        $display("test multi session done");

        // Single-session option, the unprogrammed default
        do_reset(1'b1);
        lock_seq(8'h40);
        rd_chk("one-way lock set", `OSC_CONTROL_OFFSET, 32'h40);
        lock_seq(8'h00);
        rd_chk("one-way lock held", `OSC_CONTROL_OFFSET, 32'h40);
        wr(`INPUT_MAP_OFFSET, 32'h0000_0304);
        rd_chk("one-way map held", `INPUT_MAP_OFFSET, 32'h1f1f);
        do_reset(1'b1);
        rd_chk("reset unlocks", `OSC_CONTROL_OFFSET, 32'h0);
        wr(`INPUT_MAP_OFFSET, 32'h0000_0304);
        rd_chk("reset reopens map", `INPUT_MAP_OFFSET, 32'h0304);
        check("no mismatch", {31'h0, mismatch_reset}, 32'h0);
        $display("test single session done");
        wrap_up();
    end
endmodule : pin_select_write_lock_tb_top
